//--- pafd_top.sv
// parameter access filter with direction lock and user group
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - lock 0 both, 1 no reverse, 2 no forward
// R2 - lock gates keys, terminals and communication alike
// R3 - scope 9999 simple, 0 extended, 1 group
// R4 - count read gives registered entries 0..16
// R5 - count write 9999 clears whole group
// R6 - add write 0..999 registers that parameter
// R7 - remove write 0..999 deletes that parameter
// R8 - add and remove always read 9999; code answers 0 to a refused local read of them
// R9 - lock and group writes need scope 0
// R10 - scope writable while running, any mode
// R11 - group holds at most sixteen numbers
// R12 - scope 1 refuses reads of non-members
// R13 - communication reads ignore display scope
// R14 - rs485 reads reach every parameter
// R15 - protect, scope, contrast always readable locally
// R16 - protect, scope, group parameters never registered
// R17 - other count writes, remove 9999: no effect
// R18 - handheld makes jog and contrast simple
// R19 - fitted option card parameters readable
// R20 - operator stops drive before panel editing
// R21 - full group or duplicate: no change
// R22 - protect 0: panel writes only when stopped
module pafd_top
  import pafd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [1:0]  acc_source,
  input  wire logic [9:0]  acc_num,
  input  wire logic [15:0] acc_wdata,
  input  wire logic        acc_is_simple,
  input  wire logic        acc_is_option,
  output logic             acc_done,
  output logic             acc_ok,
  output logic             acc_own,
  output logic [15:0]      acc_rdata,
  input  wire logic [15:0] write_protect_select,
  input  wire logic        motor_running,
  input  wire logic        local_keypad_mode,
  input  wire logic        handheld_attached,
  input  wire logic        comm_option_card,
  input  wire logic        panel_fwd_key,
  input  wire logic        panel_rev_key,
  input  wire logic        handheld_fwd_key,
  input  wire logic        handheld_rev_key,
  input  wire logic        forward_start_in,
  input  wire logic        reverse_start_in,
  input  wire logic        comm_fwd_cmd,
  input  wire logic        comm_rev_cmd,
  output logic             panel_fwd_ok,
  output logic             panel_rev_ok,
  output logic             handheld_fwd_ok,
  output logic             handheld_rev_ok,
  output logic             term_fwd_ok,
  output logic             term_rev_ok,
  output logic             comm_fwd_ok,
  output logic             comm_rev_ok,
  output logic [15:0]      direction_lock_select,
  output logic [15:0]      display_scope_select
);

  logic [15:0] dir_lock_r;
  logic [15:0] scope_r;
  logic        done_r;
  logic        ok_r;
  logic        own_r;
  logic [15:0] rdata_r;
  logic        group_hit;
  logic [4:0]  group_count;

  //////////////////////////////////////////////////////////////////////////
  // direction lock on every run command source

  pafd_dir_gate u_gate_panel (
    .clock  (clock),
    .rst    (rst),
    .lock   (dir_lock_r),
    .fwd_in (panel_fwd_key),
    .rev_in (panel_rev_key),
    .fwd_ok (panel_fwd_ok),
    .rev_ok (panel_rev_ok)
  ); // see R2

  pafd_dir_gate u_gate_handheld (
    .clock  (clock),
    .rst    (rst),
    .lock   (dir_lock_r),
    .fwd_in (handheld_fwd_key),
    .rev_in (handheld_rev_key),
    .fwd_ok (handheld_fwd_ok),
    .rev_ok (handheld_rev_ok)
  ); // see R2

  pafd_dir_gate u_gate_term (
    .clock  (clock),
    .rst    (rst),
    .lock   (dir_lock_r),
    .fwd_in (forward_start_in),
    .rev_in (reverse_start_in),
    .fwd_ok (term_fwd_ok),
    .rev_ok (term_rev_ok)
  ); // see R2

  pafd_dir_gate u_gate_comm (
    .clock  (clock),
    .rst    (rst),
    .lock   (dir_lock_r),
    .fwd_in (comm_fwd_cmd),
    .rev_in (comm_rev_cmd),
    .fwd_ok (comm_fwd_ok),
    .rev_ok (comm_rev_ok)
  ); // see R2

  //////////////////////////////////////////////////////////////////////////
  // request decode

  wire is_dir   = (acc_num == PAFD_NUM_DIR);
  wire is_scope = (acc_num == PAFD_NUM_SCOPE);
  wire is_count = (acc_num == PAFD_NUM_COUNT);
  wire is_add   = (acc_num == PAFD_NUM_ADD);
  wire is_del   = (acc_num == PAFD_NUM_DEL);
  wire is_own   = is_dir | is_scope | is_count | is_add | is_del;
  wire is_local = (acc_source == PAFD_SRC_PANEL) ||
                  (acc_source == PAFD_SRC_HANDHELD);
  wire rd_req   = acc_valid && !acc_write;
  wire wr_req   = acc_valid && acc_write;

  //////////////////////////////////////////////////////////////////////////
  // read filter: only keypad and handheld reads are narrowed

  wire always_rd = (acc_num == PAFD_NUM_WP) || is_scope ||
                   (acc_num == PAFD_NUM_CONTRAST); // see R15
  wire hh_simple = handheld_attached &&
                   ((acc_num == PAFD_NUM_JOG_FREQ) ||
                    (acc_num == PAFD_NUM_JOG_RAMP) ||
                    (acc_num == PAFD_NUM_CONTRAST)); // see R18
  wire opt_rd    = acc_is_option && comm_option_card; // see R19
  wire simple_rd = acc_is_simple || hh_simple || opt_rd;
  wire scope_rd  = (scope_r == PAFD_SCOPE_EXT) ||
                   ((scope_r == PAFD_SCOPE_SIMPLE) && simple_rd) ||
                   ((scope_r == PAFD_SCOPE_GROUP) && group_hit); // see R3
  // communication reads bypass the scope entirely
  wire rd_allow  = !is_local || always_rd || scope_rd; // see R13 R14 R12

  //////////////////////////////////////////////////////////////////////////
  // write filter

  // the stop-only protect level also needs the keypad mode for local edits
  wire wp_ok     = !is_local ||
                   (write_protect_select == PAFD_WP_ANY) ||
                   ((write_protect_select == PAFD_WP_STOP) &&
                    !motor_running && local_keypad_mode); // see R22
  wire grp_gate  = (scope_r == PAFD_SCOPE_EXT) && wp_ok; // see R9
  wire scope_val = (acc_wdata == PAFD_SCOPE_SIMPLE) ||
                   (acc_wdata == PAFD_SCOPE_EXT) ||
                   (acc_wdata == PAFD_SCOPE_GROUP);
  wire dir_val   = (acc_wdata == PAFD_LOCK_BOTH) ||
                   (acc_wdata == PAFD_LOCK_REV) ||
                   (acc_wdata == PAFD_LOCK_FWD);
  wire num_val   = (acc_wdata <= PAFD_NUM_MAX);
  wire grp_val   = num_val || (acc_wdata == PAFD_VAL_NONE);
  wire resv_num  = (acc_wdata[9:0] == PAFD_NUM_WP) ||
                   (acc_wdata[9:0] == PAFD_NUM_SCOPE) ||
                   (acc_wdata[9:0] == PAFD_NUM_COUNT) ||
                   (acc_wdata[9:0] == PAFD_NUM_ADD) ||
                   (acc_wdata[9:0] == PAFD_NUM_DEL);
  wire add_resv  = num_val && resv_num; // see R16

  // the scope selector ignores run state and protect level
  wire wr_scope  = wr_req && is_scope && scope_val; // see R10
  wire wr_dir    = wr_req && is_dir && grp_gate && dir_val; // see R1 R9
  wire wr_count  = wr_req && is_count && grp_gate; // see R17
  wire wr_add    = wr_req && is_add && grp_gate && grp_val && !add_resv;
  wire wr_del    = wr_req && is_del && grp_gate && grp_val;
  wire clr_en    = wr_count && (acc_wdata == PAFD_VAL_NONE); // see R5
  wire add_en    = wr_add && num_val; // see R6
  wire del_en    = wr_del && num_val; // see R7 R17

  wire wr_allow  = is_own ? (wr_scope | wr_dir | wr_count | wr_add |
                             wr_del)
                          : wp_ok;

  //////////////////////////////////////////////////////////////////////////
  // read data of the filter's own parameters

  wire [15:0] own_rdata =
    is_dir   ? dir_lock_r :
    is_scope ? scope_r :
    is_count ? {11'h000, group_count} : // see R4
    (is_add || is_del) ? PAFD_VAL_NONE : // see R8
    16'h0000;

  //////////////////////////////////////////////////////////////////////////
  // user group registry

  pafd_group_cam u_group (
    .clock       (clock),
    .rst         (rst),
    .add_en      (add_en),
    .del_en      (del_en),
    .clr_en      (clr_en),
    .upd_num     (acc_wdata[9:0]),
    .look_num    (acc_num),
    .look_hit    (group_hit),
    .group_count (group_count)
  ); // see R11

  //////////////////////////////////////////////////////////////////////////
  // setting registers and answer

  always_ff @(posedge clock) begin
    if (rst) begin
      dir_lock_r <= PAFD_DIR_RST;
      scope_r    <= PAFD_SCOPE_RST;
    end else begin
      if (wr_dir) begin
        dir_lock_r <= acc_wdata;
      end
      if (wr_scope) begin
        scope_r <= acc_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      done_r  <= 1'b0;
      ok_r    <= 1'b0;
      own_r   <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      done_r  <= acc_valid;
      ok_r    <= acc_write ? wr_allow : rd_allow;
      own_r   <= is_own;
      rdata_r <= (rd_req && rd_allow) ? own_rdata : 16'h0000;
    end
  end

  assign acc_done              = done_r;
  assign acc_ok                = ok_r;
  assign acc_own               = own_r;
  assign acc_rdata             = rdata_r;
  assign direction_lock_select = dir_lock_r;
  assign display_scope_select  = scope_r;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // a refused local read answers 0, so only passed reads are held to 9999
  sequence s_read_group_param;
    rd_req && (is_add || is_del) && rd_allow;
  endsequence

  sequence s_answer_none;
    acc_done && acc_ok && (acc_rdata == PAFD_VAL_NONE);
  endsequence

  property p_no_reverse;
    (dir_lock_r == PAFD_LOCK_REV) |=>
      !(panel_rev_ok || handheld_rev_ok || term_rev_ok || comm_rev_ok);
  endproperty
  a_no_reverse: assert property (p_no_reverse) // see R1 R2
    else $error("reverse command passed while reverse is locked");

  property p_no_forward;
    (dir_lock_r == PAFD_LOCK_FWD) |=>
      !(panel_fwd_ok || handheld_fwd_ok || term_fwd_ok || comm_fwd_ok);
  endproperty
  a_no_forward: assert property (p_no_forward) // see R1 R2
    else $error("forward command passed while forward is locked");

  property p_count_range;
    group_count <= PAFD_GROUP_FULL;
  endproperty
  a_count_range: assert property (p_count_range) // see R4 R11
    else $error("group count above sixteen");

  property p_clear;
    clr_en |=> (group_count == 5'h00) ##1
      (group_count == 5'h00 || $past(add_en));
  endproperty
  a_clear: assert property (p_clear) // see R5
    else $error("batch clear left entries");

  property p_read_none;
    s_read_group_param |=> s_answer_none;
  endproperty
  a_read_none: assert property (p_read_none) // see R8
    else $error("add or remove read did not return 9999");

  property p_scope_gate;
    (wr_req && is_dir && scope_r != PAFD_SCOPE_EXT) |=>
      (!acc_ok && $stable(dir_lock_r));
  endproperty
  a_scope_gate: assert property (p_scope_gate) // see R9
    else $error("lock written while scope not 0");

  property p_scope_run;
    (wr_req && is_scope && acc_wdata == PAFD_SCOPE_GROUP && motor_running)
      |=> (scope_r == PAFD_SCOPE_GROUP && acc_ok);
  endproperty
  a_scope_run: assert property (p_scope_run) // see R10
    else $error("scope write refused while running");

  property p_member_only;
    (rd_req && is_local && scope_r == PAFD_SCOPE_GROUP && !group_hit &&
     !always_rd) |=> (acc_done && !acc_ok);
  endproperty
  a_member_only: assert property (p_member_only) // see R12
    else $error("non-member read allowed in group scope");

  property p_comm_read;
    (rd_req && !is_local) |=> (acc_done && acc_ok);
  endproperty
  a_comm_read: assert property (p_comm_read) // see R13 R14
    else $error("communication read refused");

  property p_always_rd;
    (rd_req && always_rd) |=> acc_ok;
  endproperty
  a_always_rd: assert property (p_always_rd) // see R15
    else $error("always readable parameter refused");

  property p_reserved;
    (wr_req && is_add && add_resv) |=> (!acc_ok && $stable(group_count));
  endproperty
  a_reserved: assert property (p_reserved) // see R16
    else $error("reserved number registered");

  property p_panel_run;
    (wr_req && is_local && is_dir && motor_running &&
     write_protect_select == PAFD_WP_STOP) |=> !acc_ok;
  endproperty
  a_panel_run: assert property (p_panel_run) // see R22
    else $error("panel write accepted while running");

endmodule
`default_nettype wire

//--- pafd_pkg.sv
// constants for the parameter access filter and direction lock
package pafd_pkg;

  // parameter numbers handled or referenced by the filter
  localparam logic [9:0]  PAFD_NUM_WP       = 10'h04d;
  localparam logic [9:0]  PAFD_NUM_DIR      = 10'h04e;
  localparam logic [9:0]  PAFD_NUM_SCOPE    = 10'h0a0;
  localparam logic [9:0]  PAFD_NUM_COUNT    = 10'h0ac;
  localparam logic [9:0]  PAFD_NUM_ADD      = 10'h0ad;
  localparam logic [9:0]  PAFD_NUM_DEL      = 10'h0ae;
  localparam logic [9:0]  PAFD_NUM_CONTRAST = 10'h3df;
  localparam logic [9:0]  PAFD_NUM_JOG_FREQ = 10'h00f;
  localparam logic [9:0]  PAFD_NUM_JOG_RAMP = 10'h010;
  localparam logic [15:0] PAFD_NUM_MAX      = 16'h03e7;

  // setting values
  localparam logic [15:0] PAFD_VAL_NONE     = 16'h270f;
  localparam logic [15:0] PAFD_LOCK_BOTH    = 16'h0000;
  localparam logic [15:0] PAFD_LOCK_REV     = 16'h0001;
  localparam logic [15:0] PAFD_LOCK_FWD     = 16'h0002;
  localparam logic [15:0] PAFD_SCOPE_SIMPLE = 16'h270f;
  localparam logic [15:0] PAFD_SCOPE_EXT    = 16'h0000;
  localparam logic [15:0] PAFD_SCOPE_GROUP  = 16'h0001;
  localparam logic [15:0] PAFD_WP_STOP      = 16'h0000;
  localparam logic [15:0] PAFD_WP_LOCKED    = 16'h0001;
  localparam logic [15:0] PAFD_WP_ANY       = 16'h0002;

  // reset values
  localparam logic [15:0] PAFD_DIR_RST      = 16'h0000;
  localparam logic [15:0] PAFD_SCOPE_RST    = 16'h0000;

  // user group size
  localparam int          PAFD_GROUP_DEPTH  = 16;
  localparam logic [4:0]  PAFD_GROUP_FULL   = 5'h10;

  // access source codes
  localparam logic [1:0]  PAFD_SRC_PANEL    = 2'h0;
  localparam logic [1:0]  PAFD_SRC_HANDHELD = 2'h1;
  localparam logic [1:0]  PAFD_SRC_RS485    = 2'h2;
  localparam logic [1:0]  PAFD_SRC_OPTION   = 2'h3;

endpackage

//--- pafd_dir_gate.sv
// direction lock gate for one run command source
`timescale 1ns/1ps
`default_nettype none
module pafd_dir_gate
  import pafd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] lock,
  input  wire logic        fwd_in,
  input  wire logic        rev_in,
  output logic             fwd_ok,
  output logic             rev_ok
);

  wire fwd_pass = fwd_in && (lock != PAFD_LOCK_FWD); // see R1
  wire rev_pass = rev_in && (lock != PAFD_LOCK_REV); // see R1

  always_ff @(posedge clock) begin
    if (rst) begin
      fwd_ok <= 1'b0;
      rev_ok <= 1'b0;
    end else begin
      fwd_ok <= fwd_pass;
      rev_ok <= rev_pass;
    end
  end

endmodule
`default_nettype wire

//--- pafd_group_cam.sv
// user group registry of up to sixteen parameter numbers
`timescale 1ns/1ps
`default_nettype none
module pafd_group_cam
  import pafd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       add_en,
  input  wire logic       del_en,
  input  wire logic       clr_en,
  input  wire logic [9:0] upd_num,
  input  wire logic [9:0] look_num,
  output logic            look_hit,
  output logic [4:0]      group_count
);

  logic [15:0] used_r;
  logic [9:0]  num_r [PAFD_GROUP_DEPTH];
  logic        upd_hit;
  logic [3:0]  upd_idx;
  logic        free_any;
  logic [3:0]  free_idx;

  always_comb begin
    look_hit    = 1'b0;
    upd_hit     = 1'b0;
    upd_idx     = 4'h0;
    free_any    = 1'b0;
    free_idx    = 4'h0;
    group_count = 5'h00;
    for (int i = PAFD_GROUP_DEPTH - 1; i >= 0; i--) begin
      group_count = group_count + {4'h0, used_r[i]};
      if (used_r[i] && num_r[i] == look_num) begin
        look_hit = 1'b1;
      end
      if (used_r[i] && num_r[i] == upd_num) begin
        upd_hit = 1'b1;
        upd_idx = 4'(i);
      end
      if (!used_r[i]) begin
        free_any = 1'b1;
        free_idx = 4'(i);
      end
    end
  end

  // a full group or a duplicate leaves the registry as it was
  always_ff @(posedge clock) begin
    if (rst) begin
      used_r <= 16'h0000;
    end else if (clr_en) begin
      used_r <= 16'h0000; // see R5
    end else if (add_en && !upd_hit && free_any) begin
      used_r[free_idx] <= 1'b1; // see R6
      num_r[free_idx]  <= upd_num; // see R21
    end else if (del_en && upd_hit) begin
      used_r[upd_idx] <= 1'b0; // see R7
    end
  end

  property p_full_add;
    @(posedge clock) disable iff (rst)
    (add_en && !clr_en && group_count == PAFD_GROUP_FULL)
      |=> (group_count == PAFD_GROUP_FULL);
  endproperty
  a_full_add: assert property (p_full_add) // see R11
    else $error("add into a full group changed the count");

  property p_dup_add;
    @(posedge clock) disable iff (rst)
    (add_en && !clr_en && upd_hit) |=> $stable(used_r);
  endproperty
  a_dup_add: assert property (p_dup_add) // see R21
    else $error("duplicate add changed the registry");

endmodule
`default_nettype wire

//--- pafd_panel_model.sv
// host-side model: panel, handheld, serial master and run state
`timescale 1ns/1ps
`default_nettype none
module pafd_panel_model
(
  input  wire logic        clock,
  output logic             acc_valid,
  output logic             acc_write,
  output logic [1:0]       acc_source,
  output logic [9:0]       acc_num,
  output logic [15:0]      acc_wdata,
  output logic             acc_is_simple,
  output logic             acc_is_option,
  output logic             motor_running,
  output logic             local_keypad_mode,
  input  wire logic        acc_done,
  input  wire logic        acc_ok,
  input  wire logic        acc_own,
  input  wire logic [15:0] acc_rdata
);
  initial begin
    acc_valid         = 1'b0;
    acc_write         = 1'b0;
    acc_source        = 2'h0;
    acc_num           = 10'h000;
    acc_wdata         = 16'h0000;
    acc_is_simple     = 1'b0;
    acc_is_option     = 1'b0;
    motor_running     = 1'b0;
    local_keypad_mode = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic set_state(input logic run, input logic key);
    @(posedge clock);
    #1;
    motor_running     = run;
    local_keypad_mode = key;
  endtask

  // drive stopped and keypad mode before any group edit
  task automatic edit_ready();
    set_state(1'b0, 1'b1);
  endtask

  // one request, answer taken the cycle after the taking edge
  task automatic acc(input logic [1:0] src, input logic wr,
                     input logic [9:0] num, input logic [15:0] wd,
                     input logic [1:0] fl, output logic dn,
                     output logic ok, output logic own,
                     output logic [15:0] rd);
    @(posedge clock);
    #1;
    acc_valid     = 1'b1;
    acc_write     = wr;
    acc_source    = src;
    acc_num       = num;
    acc_wdata     = wd;
    acc_is_simple = fl[0];
    acc_is_option = fl[1];
    @(posedge clock);
    #1;
    dn  = acc_done;
    ok  = acc_ok;
    own = acc_own;
    rd  = acc_rdata;
    // released valid, number and data lines never keep a stale value
    acc_valid = 1'b0;
    acc_num   = ~acc_num;
    acc_wdata = ~acc_wdata;
  endtask
endmodule
`default_nettype wire

//--- test_param_access_filter_dir_lock.sv
// self-checking bench for the parameter access filter
`timescale 1ns/1ps
`default_nettype none
module test_param_access_filter_dir_lock;
  import pafd_pkg::*;
  logic              clock, rst, handheld_attached, comm_option_card;
  logic       [15:0] write_protect_select;
  logic       [7:0]  cmd_in;
  wire logic         acc_valid, acc_write, acc_is_simple, acc_is_option;
  wire logic         acc_done, acc_ok, acc_own;
  wire logic         motor_running, local_keypad_mode;
  wire logic  [1:0]  acc_source;
  wire logic  [9:0]  acc_num;
  wire logic  [15:0] acc_wdata, acc_rdata, dir_q, scope_q;
  wire logic  [7:0]  ok_out;
  int                n_mismatch = 0;
  int                n_checks = 0;

  pafd_top i_dut (.clock(clock), .rst(rst), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_source(acc_source), .acc_num(acc_num),
    .acc_wdata(acc_wdata), .acc_is_simple(acc_is_simple),
    .acc_is_option(acc_is_option), .acc_done(acc_done), .acc_ok(acc_ok),
    .acc_own(acc_own), .acc_rdata(acc_rdata),
    .write_protect_select(write_protect_select),
    .motor_running(motor_running), .local_keypad_mode(local_keypad_mode),
    .handheld_attached(handheld_attached),
    .comm_option_card(comm_option_card),
    .panel_fwd_key(cmd_in[7]), .panel_rev_key(cmd_in[6]),
    .handheld_fwd_key(cmd_in[5]), .handheld_rev_key(cmd_in[4]),
    .forward_start_in(cmd_in[3]), .reverse_start_in(cmd_in[2]),
    .comm_fwd_cmd(cmd_in[1]), .comm_rev_cmd(cmd_in[0]),
    .panel_fwd_ok(ok_out[7]), .panel_rev_ok(ok_out[6]),
    .handheld_fwd_ok(ok_out[5]), .handheld_rev_ok(ok_out[4]),
    .term_fwd_ok(ok_out[3]), .term_rev_ok(ok_out[2]),
    .comm_fwd_ok(ok_out[1]), .comm_rev_ok(ok_out[0]),
    .direction_lock_select(dir_q), .display_scope_select(scope_q));

  pafd_panel_model i_host (.clock(clock), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_source(acc_source), .acc_num(acc_num),
    .acc_wdata(acc_wdata), .acc_is_simple(acc_is_simple),
    .acc_is_option(acc_is_option), .motor_running(motor_running),
    .local_keypad_mode(local_keypad_mode), .acc_done(acc_done),
    .acc_ok(acc_ok), .acc_own(acc_own), .acc_rdata(acc_rdata));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ax(input logic [1:0] src, input logic wr,
                    input logic [9:0] num, input logic [15:0] wd,
                    input logic [1:0] fl, input logic eok,
                    input logic [15:0] erd);
    logic        dn, ok, own, eown;
    logic [15:0] rd;
    i_host.acc(src, wr, num, wd, fl, dn, ok, own, rd);
    eown = num inside {PAFD_NUM_DIR, PAFD_NUM_SCOPE, PAFD_NUM_COUNT,
                       PAFD_NUM_ADD, PAFD_NUM_DEL};
    chk("acc_done", {15'h0, dn}, 16'h0001);
    chk("acc_ok", {15'h0, ok}, {15'h0, eok});
    if (ok) chk("acc_own", {15'h0, own}, {15'h0, eown});
    if (!wr) chk("acc_rdata", rd, erd);
  endtask

  task automatic rdp(input logic [9:0] num, input logic eok,
                     input logic [15:0] erd);
    ax(PAFD_SRC_PANEL, 1'b0, num, 16'h0000, 2'h0, eok, erd);
  endtask

  task automatic wrp(input logic [9:0] num, input logic [15:0] v,
                     input logic eok);
    ax(PAFD_SRC_PANEL, 1'b1, num, v, 2'h0, eok, 16'h0000);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("lock", dir_q, PAFD_DIR_RST);
    chk("scope", scope_q, PAFD_SCOPE_RST);
    rdp(PAFD_NUM_COUNT, 1'b1, 16'h0000);
    rdp(PAFD_NUM_ADD, 1'b1, PAFD_VAL_NONE);
    rdp(PAFD_NUM_DEL, 1'b1, PAFD_VAL_NONE);
    $display("test reset finished");
  endtask

  task automatic t_dir();
    logic [15:0] lk;
    logic [7:0]  m;
    i_host.edit_ready();
    for (int l = 0; l < 4; l++) begin
      // 3 is out of range, setting stays at 2
      lk = (l == 3) ? 16'h0002 : 16'(l);
      wrp(PAFD_NUM_DIR, 16'(l), l < 3);
      rdp(PAFD_NUM_DIR, 1'b1, lk);
      m = {4{lk != PAFD_LOCK_FWD, lk != PAFD_LOCK_REV}};
      for (int p = 0; p < 2; p++) begin
        cmd_in = p ? 8'h55 : 8'haa;
        @(posedge clock);
        #1;
        chk("dir gates", {8'h0, ok_out}, {8'h0, cmd_in & m});
      end
      cmd_in = 8'h00;
    end
    wrp(PAFD_NUM_DIR, PAFD_LOCK_BOTH, 1'b1);
    $display("test direction finished");
  endtask

  task automatic t_group();
    logic [9:0] rs [5];
    rs = '{PAFD_NUM_WP, PAFD_NUM_SCOPE, PAFD_NUM_COUNT, PAFD_NUM_ADD,
           PAFD_NUM_DEL};
    i_host.edit_ready();
    wrp(PAFD_NUM_ADD, 16'h0003, 1'b1);
    wrp(PAFD_NUM_ADD, 16'h0003, 1'b1);
    foreach (rs[i])
      wrp(PAFD_NUM_ADD, {6'h0, rs[i]}, 1'b0);
    rdp(PAFD_NUM_COUNT, 1'b1, 16'h0001);
    wrp(PAFD_NUM_DEL, PAFD_VAL_NONE, 1'b1);
    rdp(PAFD_NUM_COUNT, 1'b1, 16'h0001);
    wrp(PAFD_NUM_DEL, 16'h0003, 1'b1);
    rdp(PAFD_NUM_COUNT, 1'b1, 16'h0000);
    // seventeenth add, of 999, lands on a full group
    for (int i = 0; i < 17; i++)
      wrp(PAFD_NUM_ADD, 16'(983 + i), 1'b1);
    rdp(PAFD_NUM_COUNT, 1'b1, 16'h0010);
    $display("test group finished");
  endtask

  task automatic t_scope();
    i_host.set_state(1'b1, 1'b0);
    wrp(PAFD_NUM_SCOPE, PAFD_SCOPE_GROUP, 1'b1);
    rdp(10'd983, 1'b1, 16'h0000);
    rdp(10'd999, 1'b0, 16'h0000);
    rdp(10'd500, 1'b0, 16'h0000);
    rdp(PAFD_NUM_WP, 1'b1, 16'h0000);
    rdp(PAFD_NUM_SCOPE, 1'b1, PAFD_SCOPE_GROUP);
    rdp(PAFD_NUM_CONTRAST, 1'b1, 16'h0000);
    ax(PAFD_SRC_RS485, 1'b0, 10'd500, 16'h0, 2'h0, 1'b1, 16'h0);
    ax(PAFD_SRC_OPTION, 1'b0, 10'd500, 16'h0, 2'h0, 1'b1, 16'h0);
    i_host.edit_ready();
    wrp(PAFD_NUM_DIR, PAFD_LOCK_REV, 1'b0);
    wrp(PAFD_NUM_ADD, 16'h0005, 1'b0);
    wrp(PAFD_NUM_COUNT, PAFD_VAL_NONE, 1'b0);
    ax(PAFD_SRC_RS485, 1'b0, PAFD_NUM_COUNT, 16'h0, 2'h0, 1'b1,
       16'h0010);
    wrp(PAFD_NUM_SCOPE, PAFD_SCOPE_SIMPLE, 1'b1);
    rdp(10'd500, 1'b0, 16'h0000);
    ax(PAFD_SRC_PANEL, 1'b0, 10'd500, 16'h0, 2'h1, 1'b1, 16'h0);
    ax(PAFD_SRC_HANDHELD, 1'b0, PAFD_NUM_JOG_FREQ, 16'h0, 2'h0, 1'b0,
       16'h0);
    handheld_attached = 1'b1;
    ax(PAFD_SRC_HANDHELD, 1'b0, PAFD_NUM_JOG_RAMP, 16'h0, 2'h0, 1'b1,
       16'h0);
    comm_option_card = 1'b1;
    ax(PAFD_SRC_PANEL, 1'b0, 10'd600, 16'h0, 2'h2, 1'b1, 16'h0);
    wrp(PAFD_NUM_SCOPE, PAFD_SCOPE_EXT, 1'b1);
    wrp(PAFD_NUM_COUNT, 16'h0005, 1'b1);
    rdp(PAFD_NUM_COUNT, 1'b1, 16'h0010);
    wrp(PAFD_NUM_COUNT, PAFD_VAL_NONE, 1'b1);
    rdp(PAFD_NUM_COUNT, 1'b1, 16'h0000);
    $display("test scope finished");
  endtask

  task automatic t_protect();
    write_protect_select = PAFD_WP_STOP;
    i_host.set_state(1'b1, 1'b1);
    wrp(10'd500, 16'h0001, 1'b0);
    wrp(PAFD_NUM_DIR, PAFD_LOCK_REV, 1'b0);
    write_protect_select = PAFD_WP_ANY;
    wrp(10'd500, 16'h0001, 1'b1);
    write_protect_select = PAFD_WP_LOCKED;
    wrp(10'd500, 16'h0001, 1'b0);
    wrp(PAFD_NUM_SCOPE, PAFD_SCOPE_EXT, 1'b1);
    ax(PAFD_SRC_RS485, 1'b1, 10'd500, 16'h1, 2'h0, 1'b1, 16'h0);
    write_protect_select = PAFD_WP_STOP;
    i_host.edit_ready();
    wrp(10'd500, 16'h0001, 1'b1);
    $display("test protect finished");
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    #100000;
    n_mismatch++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    rst                  = 1'b1;
    handheld_attached    = 1'b0;
    comm_option_card     = 1'b0;
    write_protect_select = PAFD_WP_STOP;
    cmd_in               = 8'h00;
    repeat (8) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset();
    t_dir();
    t_group();
    t_scope();
    t_protect();
    finish_test();
  end
endmodule
`default_nettype wire
